/* File: pkg/dvb_pkg.sv */
package dvb_pkg;

  // ****************************************
  // Command fields
  // ****************************************
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int NUM_SP = 2;
  localparam int NUM_CH = 2;
  localparam int NUM_BANK = 8;
  localparam int NUM_LANE = 8;

  // ****************************************
  // Mode register addresses
  // ****************************************
  localparam logic [5:0] ADDR_REF_LEVEL = 6'h0e;
  localparam logic [5:0] ADDR_PAT_INVERT = 6'h0f;
  localparam logic [5:0] ADDR_BANK_MASK = 6'h10;

  // ****************************************
  // Field layout of the reference level register
  // ****************************************
  localparam int LEVEL_LSB = 0;
  localparam int LEVEL_W = 6;
  localparam int RANGE_BIT = 6;
  localparam int RSVD_BIT = 7;
  localparam logic [5:0] LEVEL_MAX = 6'h32;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [5:0] LEVEL_RST = 6'h1d;
  localparam logic RANGE_RST = 1'b1;
  localparam logic [7:0] INVERT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic range;
    logic [LEVEL_W-1:0] level;
  } dvb_ref_t;

  typedef struct packed {
    dvb_ref_t [NUM_SP-1:0] sp;
    dvb_ref_t act;
    logic act_level_valid;
    logic [NUM_LANE-1:0] invert;
    logic [NUM_CH-1:0][NUM_BANK-1:0] mask;
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
  } dvb_regs_t;

  typedef struct packed {
    logic [NUM_LANE-1:0] dq;
    logic mask_inversion_lane;
    logic dbi_active;
  } dvb_cal_t;

endpackage : dvb_pkg

/* File: rtl/dvb_cal_lanes.sv */
`timescale 1ns/1ps
module dvb_cal_lanes (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cal_active_i,
  input wire logic pattern_bit_i,
  input wire logic [dvb_pkg::NUM_LANE-1:0] invert_i,
  input wire logic dbi_enable_i,
  output logic [dvb_pkg::NUM_LANE-1:0] cal_dq_o,
  output logic cal_dmi_o,
  output logic dbi_active_o
);

  dvb_pkg::dvb_cal_t state;
  dvb_pkg::dvb_cal_t next_state;
  logic [dvb_pkg::NUM_LANE-1:0] lane_bits;

  // ****************************************
  // Per-lane inversion
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < dvb_pkg::NUM_LANE; g++) begin : g_lane
      assign lane_bits[g] = pattern_bit_i ^ invert_i[g]; // RL7
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_state.dq = cal_active_i ? lane_bits : '0;
    // The mask lane bypasses the invert mask entirely.
    next_state.mask_inversion_lane = cal_active_i & pattern_bit_i; // RL8
    next_state.dbi_active = dbi_enable_i & ~cal_active_i; // RL9
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign cal_dq_o = state.dq;
  assign cal_dmi_o = state.mask_inversion_lane;
  assign dbi_active_o = state.dbi_active;

endmodule : dvb_cal_lanes

/* File: rtl/dvb_regs.sv */
`timescale 1ns/1ps
// Contract
// RL1: A read of the reference register returns its eight bits, reserved bits zero.
// RL2: Level writes land in set point zero or one per access select.
// RL3: Bit 6 picks range; values persist until overwritten or reset.
// RL4: Every reference bit exists per set point; accesses reach the selected copy.
// RL5: Operation uses only the operate-selected copy; the other is ignored.
// RL6: Level codes zero to 0x32 are valid; range one default code 0x1d.
// RL7: Invert mask bit n inverts the calibration pattern on lane n.
// RL8: The mask inversion lane always carries the true pattern.
// RL9: No bus inversion coding during read calibration.
// RL10: Bank mask bit n set stops refresh of bank n; default unmasked.
// RL11: Bank masks are held separately for each channel.
// RL12: Reference register sits at mode register address 0x0e.
// RL13: Reserved bit 7 ignores writes and reads as zero.
module dvb_regs (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic mrw_i,
  input wire logic mrr_i,
  input wire logic channel_i,
  input wire logic [dvb_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dvb_pkg::DATA_W-1:0] op_i,
  input wire logic setpoint_access_select_i,
  input wire logic setpoint_operate_select_i,
  input wire logic cal_active_i,
  input wire logic pattern_bit_i,
  input wire logic dbi_enable_i,
  output logic [dvb_pkg::DATA_W-1:0] rd_dq_o,
  output logic rd_valid_o,
  output logic [dvb_pkg::LEVEL_W-1:0] ref_level_o,
  output logic ref_range_o,
  output logic ref_level_valid_o,
  output logic [dvb_pkg::NUM_BANK-1:0] bank_mask_ch0_o,
  output logic [dvb_pkg::NUM_BANK-1:0] bank_mask_ch1_o,
  output logic [dvb_pkg::NUM_LANE-1:0] cal_dq_o,
  output logic cal_dmi_o,
  output logic dbi_active_o
);

  dvb_pkg::dvb_regs_t state;
  dvb_pkg::dvb_regs_t next_state;
  dvb_pkg::dvb_ref_t sel_copy;
  dvb_pkg::dvb_ref_t op_copy;

  // ****************************************
  // Register update
  // ****************************************
  always_comb begin
    next_state = state;
    sel_copy = state.sp[setpoint_access_select_i]; // RL4
    op_copy = state.sp[setpoint_operate_select_i]; // RL5
    next_state.rd_valid = 1'b0;
    next_state.rd_data = dvb_pkg::DATA_ZERO;
    if (mrw_i) begin
      case (addr_i)
        dvb_pkg::ADDR_REF_LEVEL: begin // RL12
          // Range and level are written together, bit 7 is dropped.
          next_state.sp[setpoint_access_select_i].level =
            op_i[dvb_pkg::LEVEL_LSB +: dvb_pkg::LEVEL_W]; // RL2
          next_state.sp[setpoint_access_select_i].range = op_i[dvb_pkg::RANGE_BIT]; // RL3
        end
        dvb_pkg::ADDR_PAT_INVERT: begin
          next_state.invert = op_i; // RL7
        end
        dvb_pkg::ADDR_BANK_MASK: begin
          next_state.mask[channel_i] = op_i; // RL11
        end
        default: begin
          next_state.invert = state.invert;
        end
      endcase
    end
    if (mrr_i) begin
      next_state.rd_valid = 1'b1;
      case (addr_i)
        dvb_pkg::ADDR_REF_LEVEL: begin
          next_state.rd_data = dvb_pkg::DATA_ZERO;
          next_state.rd_data[dvb_pkg::LEVEL_LSB +: dvb_pkg::LEVEL_W] = sel_copy.level; // RL1
          next_state.rd_data[dvb_pkg::RANGE_BIT] = sel_copy.range;
          next_state.rd_data[dvb_pkg::RSVD_BIT] = 1'b0; // RL13
        end
        default: begin
          // Write-only and unmapped addresses answer with zeros.
          next_state.rd_data = dvb_pkg::DATA_ZERO;
        end
      endcase
    end
    next_state.act = op_copy; // RL5
    // Reserved codes are stored as written but flagged so the analog side can hold off.
    next_state.act_level_valid = (op_copy.level <= dvb_pkg::LEVEL_MAX); // RL6
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state.sp[0].level <= dvb_pkg::LEVEL_RST; // RL6
      state.sp[0].range <= dvb_pkg::RANGE_RST;
      state.sp[1].level <= dvb_pkg::LEVEL_RST;
      state.sp[1].range <= dvb_pkg::RANGE_RST;
      state.act.level <= dvb_pkg::LEVEL_RST;
      state.act.range <= dvb_pkg::RANGE_RST;
      state.act_level_valid <= 1'b1;
      state.invert <= dvb_pkg::INVERT_RST;
      state.mask[0] <= dvb_pkg::MASK_RST; // RL10
      state.mask[1] <= dvb_pkg::MASK_RST;
      state.rd_data <= dvb_pkg::DATA_ZERO;
      state.rd_valid <= 1'b0;
    end else begin
      state <= next_state; // RL3
    end
  end

  // ****************************************
  // Calibration lanes
  // ****************************************
  dvb_cal_lanes u_cal (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .cal_active_i(cal_active_i),
    .pattern_bit_i(pattern_bit_i),
    .invert_i(state.invert),
    .dbi_enable_i(dbi_enable_i),
    .cal_dq_o(cal_dq_o),
    .cal_dmi_o(cal_dmi_o),
    .dbi_active_o(dbi_active_o)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign rd_dq_o = state.rd_data;
  assign rd_valid_o = state.rd_valid;
  assign ref_level_o = state.act.level;
  assign ref_range_o = state.act.range;
  assign ref_level_valid_o = state.act_level_valid;
  // A set bit masks that bank from refresh.
  assign bank_mask_ch0_o = state.mask[0]; // RL10
  assign bank_mask_ch1_o = state.mask[1];

endmodule : dvb_regs

/* File: test/dvb_regs_chk.sv */
`timescale 1ns/1ps
module dvb_regs_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic mrw_i,
  input wire logic mrr_i,
  input wire logic channel_i,
  input wire logic [5:0] addr_i,
  input wire logic [7:0] op_i,
  input wire logic cal_active_i,
  input wire logic pattern_bit_i,
  input wire logic dbi_enable_i,
  input wire logic [7:0] rd_dq_o,
  input wire logic rd_valid_o,
  input wire logic [5:0] ref_level_o,
  input wire logic ref_level_valid_o,
  input wire logic [7:0] cal_dq_o,
  input wire logic [7:0] bank_mask_ch0_o,
  input wire logic [7:0] bank_mask_ch1_o,
  input wire logic cal_dmi_o,
  input wire logic dbi_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_wr0;
    mrw_i && addr_i == 6'h10 && !channel_i;
  endsequence
  sequence s_wr1;
    mrw_i && addr_i == 6'h10 && channel_i;
  endsequence
  read_pulse_a: assert property (mrr_i |=> rd_valid_o)
    else $error("read answer missing");
  read_idle_a: assert property (!rd_valid_o |-> rd_dq_o == 8'h00)
    else $error("data without read");
  reserved_bit_a: assert property (rd_valid_o |-> !rd_dq_o[7])
    else $error("reserved bit set");
  write_only_a: assert property (mrr_i && addr_i != 6'h0e |=> rd_dq_o == 8'h00)
    else $error("write-only read");
  mask_ch0_a: assert property (s_wr0 |=> bank_mask_ch0_o == $past(op_i) && $stable(bank_mask_ch1_o))
    else $error("mask ch0 wrong");
  mask_ch1_a: assert property (s_wr1 |=> bank_mask_ch1_o == $past(op_i) && $stable(bank_mask_ch0_o))
    else $error("mask ch1 wrong");
  dmi_true_a: assert property (cal_active_i |=> cal_dmi_o == $past(pattern_bit_i))
    else $error("mask lane inverted");
  dbi_off_a: assert property (cal_active_i |=> !dbi_active_o)
    else $error("inversion in calibration");
  read_once_a: assert property (!mrr_i |=> !rd_valid_o)
    else $error("read answer without read");
  dbi_follow_a: assert property (!cal_active_i |=> dbi_active_o == $past(dbi_enable_i))
    else $error("inversion enable not followed");
  cal_idle_a: assert property (!cal_active_i |=> cal_dq_o == 8'h00 && !cal_dmi_o)
    else $error("pattern outside calibration");
  level_valid_a: assert property (ref_level_valid_o == (ref_level_o <= 6'h32))
    else $error("level valid flag wrong");
endmodule : dvb_regs_chk
bind dvb_regs dvb_regs_chk i_chk (.*);

/* File: test/dvb_ctl_model.sv */
`timescale 1ns/1ps
module dvb_ctl_model (
  input wire logic clk_i,
  input wire logic [7:0] rd_dq_i,
  output logic mrw_o,
  output logic mrr_o,
  output logic [5:0] addr_o,
  output logic [7:0] op_o
);
  initial begin
    mrw_o = 1'b0;
    mrr_o = 1'b0;
    addr_o = 6'h00;
    op_o = 8'h00;
  end
  // Released address and data lines show the inverse so stale values never look valid.
  task automatic cmd(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i) #1;
    mrw_o = w;
    mrr_o = !w;
    addr_o = a;
    op_o = d;
    @(posedge clk_i) #1;
    q = rd_dq_i;
    mrw_o = 1'b0;
    mrr_o = 1'b0;
    addr_o = ~a;
    op_o = ~d;
  endtask : cmd
endmodule : dvb_ctl_model

/* File: test/dvb_regs_tb.sv */
`timescale 1ns/1ps
module dvb_regs_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic mrw_i, mrr_i, rd_valid_o, ref_range_o, ref_level_valid_o, cal_dmi_o, dbi_active_o;
  logic channel_i = 1'b0, sa = 1'b0, so = 1'b0, cal_active_i = 1'b0, pattern_bit_i = 1'b0, dbi_enable_i = 1'b1;
  logic [5:0] addr_i, ref_level_o;
  logic [7:0] op_i, rd_dq_o, bank_mask_ch0_o, bank_mask_ch1_o, cal_dq_o, q, v;
  logic [7:0] mk [2] = '{8'h00, 8'h00};
  logic [6:0] sp [2] = '{7'h5d, 7'h5d};
  int miscompares = 0, comparisons = 0;
  always #2 clk_i = ~clk_i;
  dvb_ctl_model i_ctl (.clk_i, .rd_dq_i(rd_dq_o), .mrw_o(mrw_i), .mrr_o(mrr_i), .addr_o(addr_i), .op_o(op_i));
  dvb_regs i_dut (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .mrw_i(mrw_i),
    .mrr_i(mrr_i),
    .channel_i(channel_i),
    .addr_i(addr_i),
    .op_i(op_i),
    .setpoint_access_select_i(sa),
    .setpoint_operate_select_i(so),
    .cal_active_i(cal_active_i),
    .pattern_bit_i(pattern_bit_i),
    .dbi_enable_i(dbi_enable_i),
    .rd_dq_o(rd_dq_o),
    .rd_valid_o(rd_valid_o),
    .ref_level_o(ref_level_o),
    .ref_range_o(ref_range_o),
    .ref_level_valid_o(ref_level_valid_o),
    .bank_mask_ch0_o(bank_mask_ch0_o),
    .bank_mask_ch1_o(bank_mask_ch1_o),
    .cal_dq_o(cal_dq_o),
    .cal_dmi_o(cal_dmi_o),
    .dbi_active_o(dbi_active_o)
  );
  function automatic logic [7:0] ref_exp(input logic [6:0] s);
    return {1'b0, s};
  endfunction : ref_exp
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #20000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    void'($urandom(82800));
    repeat (4) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    i_ctl.cmd(1'b0, 6'h0e, 8'h00, q);
    chk(q, 8'h5d);
    chk({1'b0, ref_range_o, ref_level_o}, 8'h5d);
    chk({7'h00, ref_level_valid_o}, 8'h01);
    chk(bank_mask_ch0_o | bank_mask_ch1_o, 8'h00);
    for (int i = 0; i < 24; i++) begin
      v = (i == 0) ? 8'hb2 : 8'($urandom);
      sa = 1'($urandom);
      so = 1'($urandom);
      i_ctl.cmd(1'b1, 6'h0e, v, q);
      sp[sa] = v[6:0];
      i_ctl.cmd(1'b0, 6'h0e, 8'h00, q);
      chk(q, ref_exp(sp[sa]));
      chk({1'b0, ref_range_o, ref_level_o}, ref_exp(sp[so]));
      chk({7'h00, ref_level_valid_o}, {7'h00, sp[so][5:0] <= 6'h32});
    end
    for (int i = 0; i < 8; i++) begin
      channel_i = i[0];
      v = 8'($urandom) | (8'h01 << i);
      mk[channel_i] = v;
      i_ctl.cmd(1'b1, 6'h10, v, q);
      chk(bank_mask_ch0_o, mk[0]);
      chk(bank_mask_ch1_o, mk[1]);
    end
    i_ctl.cmd(1'b1, 6'h11, 8'hff, q);
    chk(bank_mask_ch0_o, mk[0]);
    i_ctl.cmd(1'b0, 6'h10, 8'h00, q);
    chk(q, 8'h00);
    cal_active_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      pattern_bit_i = i[0];
      i_ctl.cmd(1'b1, 6'h0f, v, q);
      @(posedge clk_i) #1;
      chk(cal_dq_o, v ^ {8{pattern_bit_i}});
      chk({6'h00, cal_dmi_o, dbi_active_o}, {6'h00, pattern_bit_i, 1'b0});
    end
    i_ctl.cmd(1'b0, 6'h0f, 8'h00, q);
    chk(q, 8'h00);
    cal_active_i = 1'b0;
    for (int i = 0; i < 2; i++) begin
      dbi_enable_i = ~dbi_enable_i;
      @(posedge clk_i) #1;
      chk(cal_dq_o, 8'h00);
      chk({6'h00, cal_dmi_o, dbi_active_o}, {6'h00, 1'b0, dbi_enable_i});
    end
    rstn_i = 1'b0;
    @(posedge clk_i) #1 rstn_i = 1'b1;
    i_ctl.cmd(1'b0, 6'h0e, 8'h00, q);
    chk(q, 8'h5d);
    chk({1'b0, ref_range_o, ref_level_o}, 8'h5d);
    chk(bank_mask_ch0_o | bank_mask_ch1_o, 8'h00);
    report_and_stop();
  end
endmodule : dvb_regs_tb
